//--- src/apms_pkg.sv
// constants shared by the power-mode sequencer design files
package apms_pkg;
   localparam logic [7:0] APMS_PWR_OFFSET = 8'h00;
   localparam logic [7:0] APMS_SCAN_OFFSET = 8'h04;
   localparam logic [7:0] APMS_STAT_OFFSET = 8'h08;
   localparam int APMS_PD_A_BIT = 0;
   localparam int APMS_PD_B_BIT = 1;
   localparam int APMS_AUTO_PD_BIT = 3;
   localparam int APMS_DLY_LSB = 4;
   localparam int APMS_DLY_MSB = 9;
   localparam int APMS_STS_A_BIT = 10;
   localparam int APMS_STS_B_BIT = 11;
   localparam int APMS_AUTO_SB_BIT = 15;
   localparam logic [5:0] APMS_DLY_RESET = 6'h0d;
   localparam logic [15:0] APMS_PWR_FIXED_ONES = 16'h1004;
   localparam logic [15:0] APMS_PWR_RSVD_ZEROS = 16'h6000;
   localparam logic [1:0] APMS_RESP_OKAY = 2'h0;
   localparam logic [1:0] APMS_RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {APMS_IDLE, APMS_DELAY, APMS_SCAN} apms_state_type;
endpackage

//--- src/apms_delay.sv
// power-up delay down-counter with zero release
`timescale 1ns/1ps
`default_nettype none
module apms_delay (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic load,
   input wire logic [5:0] value,
   output logic busy
);
   logic [5:0] cnt_reg;
   logic [5:0] cnt_next;
   assign cnt_next = load ? value : (cnt_reg != 6'h00 ? cnt_reg - 6'h01 : 6'h00);
   assign busy = (cnt_reg != 6'h00);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= 6'h00;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
   count_down_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (!load && busy) |=> cnt_reg == $past(cnt_reg) - 6'h01)
      else $error("delay counter did not step down");
endmodule
`default_nettype wire

//--- src/apms_axil.sv
// axi4-lite slave front end, one write and one read at a time
`timescale 1ns/1ps
`default_nettype none
module apms_axil (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic wr_pulse,
   output logic [7:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_ok,
   output logic [7:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);
   logic aw_reg;
   logic w_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   assign awready = !aw_reg && !bvalid_reg;
   assign wready = !w_reg && !bvalid_reg;
   assign wr_pulse = aw_reg && w_reg && !bvalid_reg;
   assign wr_addr = awaddr_reg;
   assign wr_data = wdata_reg;
   assign wr_strb = wstrb_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign arready = !rvalid_reg;
   assign rd_addr = araddr;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_reg <= 1'b0;
         w_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= apms_pkg::APMS_RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_reg <= 1'b1;
            awaddr_reg <= awaddr;
         end
         if (wvalid && wready) begin
            w_reg <= 1'b1;
            wdata_reg <= wdata;
            wstrb_reg <= wstrb;
         end
         if (wr_pulse) begin
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? apms_pkg::APMS_RESP_OKAY : apms_pkg::APMS_RESP_SLVERR;
         end else if (bvalid_reg && bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= apms_pkg::APMS_RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_ok ? rd_data : 32'h0;
         rresp_reg <= rd_ok ? apms_pkg::APMS_RESP_OKAY : apms_pkg::APMS_RESP_SLVERR;
      end else if (rvalid_reg && rready) begin
         rvalid_reg <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- src/apms_top.sv
// power-mode sequencer for a dual-converter adc with axi4-lite registers
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module apms_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic scan_req,
   input wire logic [1:0] scan_need,
   input wire logic scan_loop,
   input wire logic [1:0] conv_busy,
   output logic scan_go,
   output logic [1:0] conv_power_on,
   output logic [1:0] result_invalid,
   output logic standby_clk_sel,
   output logic standby_current
);
   apms_pkg::apms_state_type state_reg;
   apms_pkg::apms_state_type state_next;
   logic [15:0] pwr_reg;
   logic [1:0] pwr_on_reg;
   logic [1:0] status_reg;
   logic [1:0] status_next;
   logic [1:0] need_reg;
   logic [1:0] up_pend_reg;
   logic stby_reg;
   logic wr_pulse;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_ok;
   logic wr_ok;
   logic dly_load;
   logic dly_busy;
   wire wr_pwr = wr_pulse && wr_addr == apms_pkg::APMS_PWR_OFFSET;
   wire [15:0] pwr_wmask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
   wire [15:0] pwr_wval = (pwr_reg & ~pwr_wmask) | (wr_data[15:0] & pwr_wmask);
   wire [1:0] pd_bits = {pwr_reg[apms_pkg::APMS_PD_B_BIT], pwr_reg[apms_pkg::APMS_PD_A_BIT]};
   wire [1:0] pd_new = {pwr_wval[apms_pkg::APMS_PD_B_BIT], pwr_wval[apms_pkg::APMS_PD_A_BIT]};
   wire [5:0] dly_val = pwr_reg[apms_pkg::APMS_DLY_MSB:apms_pkg::APMS_DLY_LSB];
   // a delay written together with a power-down clear is the one counted
   wire [5:0] dly_start = wr_pwr ? pwr_wval[apms_pkg::APMS_DLY_MSB:apms_pkg::APMS_DLY_LSB] :
      dly_val;
   wire auto_pd = pwr_reg[apms_pkg::APMS_AUTO_PD_BIT];
   wire auto_sb = pwr_reg[apms_pkg::APMS_AUTO_SB_BIT] && !auto_pd;
   wire unit_active = |conv_busy;
   wire [1:0] pd_cleared = pd_bits & ~pd_new & {2{wr_pwr}};
   wire [1:0] pd_set = ~pd_bits & pd_new & {2{wr_pwr}};
   wire start_edge = state_reg == apms_pkg::APMS_IDLE && scan_req && !unit_active;
   wire need_delay = auto_pd || auto_sb || (|up_pend_reg);
   // manual clear of power-down restarts the wait; auto modes wait on each idle exit
   assign dly_load = (|pd_cleared && !auto_pd) || (start_edge && need_delay);
   wire [1:0] load_need = start_edge ? scan_need : need_reg;
   // a converter is powered when not forced down and either not auto-powered-down or needed
   wire [1:0] want_on = ~pd_bits & ({2{!auto_pd}} | (state_reg != apms_pkg::APMS_IDLE ||
      unit_active || scan_loop ? load_need : 2'b00));
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         apms_pkg::APMS_IDLE: begin
            if (start_edge) begin
               state_next = need_delay ? apms_pkg::APMS_DELAY : apms_pkg::APMS_SCAN;
            end
         end
         apms_pkg::APMS_DELAY: begin
            if (!dly_busy && !dly_load) begin
               state_next = apms_pkg::APMS_SCAN;
            end
         end
         apms_pkg::APMS_SCAN: begin
            if (!unit_active && !scan_req && !scan_loop) begin
               state_next = apms_pkg::APMS_IDLE;
            end
         end
         default: begin
            state_next = apms_pkg::APMS_IDLE;
         end
      endcase
   end
   generate
      for (genvar i = 0; i < 2; i++) begin : g_sts
         // set on power-down write wins; in auto-powerdown follows power, else clear only once the delay expires
         assign status_next[i] = pd_new[i] && wr_pwr ? 1'b1 :
            auto_pd ? !pwr_on_reg[i] :
            (up_pend_reg[i] ? (dly_busy || dly_load) : status_reg[i]);
      end
   endgenerate
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwr_reg <= {4'h0, 2'h3, apms_pkg::APMS_DLY_RESET, 4'h7} |
            apms_pkg::APMS_PWR_FIXED_ONES;
      end else if (wr_pwr) begin
         pwr_reg <= (pwr_wval | apms_pkg::APMS_PWR_FIXED_ONES) &
            ~apms_pkg::APMS_PWR_RSVD_ZEROS;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= apms_pkg::APMS_IDLE;
         status_reg <= 2'h3;
         pwr_on_reg <= 2'h0;
         need_reg <= 2'h0;
         up_pend_reg <= 2'h0;
         stby_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         status_reg <= status_next;
         pwr_on_reg <= want_on;
         if (start_edge) begin
            need_reg <= scan_need;
         end
         if (|pd_set || auto_pd) begin
            up_pend_reg <= up_pend_reg & ~pd_set & {2{!auto_pd}};
         end
         if (|pd_cleared && !auto_pd) begin
            up_pend_reg <= up_pend_reg | pd_cleared;
         end else if (!dly_busy && !dly_load) begin
            up_pend_reg <= 2'h0;
         end
         stby_reg <= auto_sb && state_next == apms_pkg::APMS_IDLE && !unit_active;
      end
   end
   apms_delay u_delay (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(dly_load),
      .value(dly_start),
      .busy(dly_busy)
   );
   assign scan_go = state_reg == apms_pkg::APMS_SCAN;
   assign conv_power_on = pwr_on_reg;
   assign result_invalid = pd_bits;
   assign standby_clk_sel = stby_reg;
   assign standby_current = stby_reg;
   wire [15:0] pwr_view = {pwr_reg[15:12], status_reg[1], status_reg[0], pwr_reg[9:0]};
   wire [31:0] stat_view = {26'h0, stby_reg, dly_busy, state_reg, pwr_on_reg};
   assign rd_ok = rd_addr == apms_pkg::APMS_PWR_OFFSET || rd_addr == apms_pkg::APMS_STAT_OFFSET;
   assign rd_data = rd_addr == apms_pkg::APMS_PWR_OFFSET ? {16'h0, pwr_view} : stat_view;
   assign wr_ok = wr_addr == apms_pkg::APMS_PWR_OFFSET;
   apms_axil u_bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(s_axi_awaddr),
      .awvalid(s_axi_awvalid),
      .awready(s_axi_awready),
      .wdata(s_axi_wdata),
      .wstrb(s_axi_wstrb),
      .wvalid(s_axi_wvalid),
      .wready(s_axi_wready),
      .bresp(s_axi_bresp),
      .bvalid(s_axi_bvalid),
      .bready(s_axi_bready),
      .araddr(s_axi_araddr),
      .arvalid(s_axi_arvalid),
      .arready(s_axi_arready),
      .rdata(s_axi_rdata),
      .rresp(s_axi_rresp),
      .rvalid(s_axi_rvalid),
      .rready(s_axi_rready),
      .wr_pulse(wr_pulse),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_ok(wr_ok),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );
   sequence pd_write_s;
      wr_pwr && pd_new[0] && !pd_bits[0];
   endsequence
   status_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      pd_write_s |=> status_reg[0])
      else $error("status a not set after power-down write");
   sts_a_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
      pwr_view[apms_pkg::APMS_STS_A_BIT] == status_reg[0])
      else $error("status a not at bit ten");
   sts_b_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
      pwr_view[apms_pkg::APMS_STS_B_BIT] == status_reg[1])
      else $error("status b not at bit eleven");
   auto_track_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ($past(auto_pd) && auto_pd && !$past(wr_pwr)) |->
      status_reg == ~$past(pwr_on_reg))
      else $error("status does not follow power in auto-powerdown");
   pd_forces_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      pd_bits[1] |=> !pwr_on_reg[1])
      else $error("converter b on while forced down");
   no_go_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ($rose(scan_go) && $past(auto_pd || auto_sb)) |->
      $past(state_reg == apms_pkg::APMS_DELAY && !dly_busy))
      else $error("scan released without the power-up delay");
   powerdown_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
      auto_pd |=> !stby_reg)
      else $error("standby selected in auto-powerdown");
   idle_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (auto_pd && state_reg == apms_pkg::APMS_IDLE && !unit_active && !scan_loop && !start_edge)
      |=> pwr_on_reg == 2'b00)
      else $error("converter left on while idle in auto-powerdown");
endmodule
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the adc power-mode sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic wvalid = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic scan_req = 1'b0;
   logic [1:0] scan_need = 2'b00;
   logic scan_loop = 1'b0;
   logic [1:0] conv_busy = 2'b00;
   logic awready, wready, bvalid, arready, rvalid, scan_go, standby_clk_sel, standby_current;
   logic [1:0] bresp, rresp, conv_power_on, result_invalid;
   logic [31:0] rdata, d;
   logic [1:0] r;
   int err_count = 0;
   int n_compared = 0;
   int dly;
   logic [1:0] need;

   always #10 aclk = ~aclk;

   apms_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
      .scan_req(scan_req), .scan_need(scan_need), .scan_loop(scan_loop), .conv_busy(conv_busy),
      .scan_go(scan_go), .conv_power_on(conv_power_on), .result_invalid(result_invalid),
      .standby_clk_sel(standby_clk_sel), .standby_current(standby_current));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   function automatic logic [31:0] pwr(logic auto_sb, logic auto_pd, logic [5:0] dl,
         logic [1:0] pd, logic [1:0] sts);
      return {16'h0, auto_sb, 2'b00, 1'b1, sts, dl, auto_pd, 1'b1, pd};
   endfunction

   task automatic axi_write(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rsp);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      awaddr <= a;
      wdata <= dat;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) begin
            awvalid <= 1'b0;
            aw_done = 1'b1;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
            w_done = 1'b1;
         end
      end while (!(aw_done && w_done));
      do begin
         @(posedge aclk);
      end while (bvalid !== 1'b1);
      rsp = bresp;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rsp);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
      end while (arready !== 1'b1);
      arvalid <= 1'b0;
      do begin
         @(posedge aclk);
      end while (rvalid !== 1'b1);
      dat = rdata;
      rsp = rresp;
   endtask

   // raise a scan request and count edges until the scan is seen permitted
   task automatic start_scan(input logic [1:0] nd, input int exp);
      int k;
      scan_req <= 1'b1;
      scan_need <= nd;
      k = 0;
      do begin
         @(posedge aclk);
         k++;
      end while (scan_go !== 1'b1 && k < 300);
      check(32'(k), 32'(exp));
   endtask

   task automatic end_scan(input logic [1:0] nd);
      @(posedge aclk);
      conv_busy <= nd;
      scan_req <= 1'b0;
      repeat (3) @(posedge aclk);
      conv_busy <= 2'b00;
      repeat (4) @(posedge aclk);
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      #(20 * 20000);
      err_count++;
      tally_and_finish();
   end

   initial begin
      void'($urandom(32'hed2b));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      axi_read(8'h00, d, r);
      check(d, 32'h1cd7);
      check({30'h0, result_invalid}, 32'h3);
      axi_read(8'h04, d, r);
      check({r, d[29:0]}, {2'h2, 30'h0});
      axi_write(8'h0c, 32'h0, r);
      check(r, 2'h2);
      // manual power-up of converter a only; status bits written as 1 must stay read-only
      dly = 8 + ($urandom % 13);
      axi_write(8'h00, pwr(1'b0, 1'b0, dly[5:0], 2'b10, 2'b11), r);
      repeat (dly - 1) @(posedge aclk);
      axi_read(8'h00, d, r);
      check(d, pwr(1'b0, 1'b0, dly[5:0], 2'b10, 2'b11));
      axi_read(8'h00, d, r);
      check(d, pwr(1'b0, 1'b0, dly[5:0], 2'b10, 2'b10));
      check({30'h0, conv_power_on}, 32'h1);
      check({30'h0, result_invalid}, 32'h2);
      axi_write(8'h00, pwr(1'b0, 1'b0, dly[5:0], 2'b11, 2'b00), r);
      axi_read(8'h00, d, r);
      check(d, pwr(1'b0, 1'b0, dly[5:0], 2'b11, 2'b11));
      check({30'h0, conv_power_on}, 32'h0);
      // both up by hand, then auto modes switched on in mid-scan
      axi_write(8'h00, pwr(1'b0, 1'b0, dly[5:0], 2'b00, 2'b00), r);
      repeat (dly + 6) @(posedge aclk);
      axi_read(8'h00, d, r);
      check(d, pwr(1'b0, 1'b0, dly[5:0], 2'b00, 2'b00));
      start_scan(2'b11, 2);
      conv_busy <= 2'b11;
      scan_req <= 1'b0;
      axi_write(8'h00, pwr(1'b1, 1'b1, dly[5:0], 2'b00, 2'b00), r);
      repeat (4) @(posedge aclk);
      check({29'h0, scan_go, conv_power_on}, 32'h7);
      check({31'h0, standby_clk_sel}, 32'h0);
      end_scan(2'b00);
      check({29'h0, scan_go, conv_power_on}, 32'h0);
      check({30'h0, standby_clk_sel, standby_current}, 32'h0);
      axi_read(8'h00, d, r);
      check(d[11:10], 2'b11);
      // auto-powerdown scans for every converter selection, random delays
      for (int i = 1; i < 4; i++) begin
         need = 2'(i);
         dly = 1 + ($urandom % 15);
         axi_write(8'h00, pwr(1'b0, 1'b1, dly[5:0], 2'b00, 2'b00), r);
         repeat (3) @(posedge aclk);
         start_scan(need, dly + 3);
         check({30'h0, conv_power_on}, {30'h0, need});
         axi_read(8'h00, d, r);
         check(d[11:10], {30'h0, ~need});
         end_scan(need);
         check({30'h0, conv_power_on}, 32'h0);
      end
      // looping scan keeps the unit out of idle
      start_scan(2'b01, dly + 3);
      scan_loop <= 1'b1;
      scan_req <= 1'b0;
      repeat (20) @(posedge aclk);
      check({29'h0, scan_go, conv_power_on}, 32'h5);
      scan_loop <= 1'b0;
      repeat (4) @(posedge aclk);
      check({30'h0, conv_power_on}, 32'h0);
      // auto-standby alone
      axi_write(8'h00, pwr(1'b1, 1'b0, dly[5:0], 2'b00, 2'b00), r);
      repeat (dly + 6) @(posedge aclk);
      check({30'h0, standby_clk_sel, standby_current}, 32'h3);
      start_scan(2'b10, dly + 3);
      check({30'h0, standby_clk_sel, standby_current}, 32'h0);
      end_scan(2'b10);
      check({30'h0, standby_clk_sel, standby_current}, 32'h3);
      tally_and_finish();
   end
endmodule
`default_nettype wire
